// ===== hw/dma_core.sv
// Two channel byte DMA with APB register access and a byte memory port.
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/10ps
`include "dma_map.svh"
// Functional notes
// RULE1 - Two independent channels, 0 and 1, each moving bytes memory to memory.
// RULE2 - Transfers start on the selected hardware request or a software trigger.
// RULE3 - Mode bit 0 gives cycle steal: one byte per request.
// RULE4 - Mode bit 1 gives burst: the whole 16-bit count per request.
// RULE5 - Index bit selects which channel the shared registers reach.
// RULE6 - Latch-only bit 0 writes working register and latch; 1 writes latch only.
// RULE7 - Software reads high byte then low, writes low byte then high.
// RULE8 - Writing the software trigger bit makes a request for that channel.
// RULE9 - Pointers step up, down or stay per mode bits 0 to 3.
// RULE10 - Underflow always reloads count; pointers reload unless reload disabled.
// RULE11 - Underflow sets the DMA interrupt request bit and channel underflow flag.
// RULE12 - With disable-on-underflow set, underflow clears the channel enable.
// RULE13 - Writing the reload bit copies latches into working registers.
// RULE14 - USB to host-bus path needs its enable, a USB source and cycle steal.
// RULE15 - Packet-ready source requests while flag set and host output buffer empty.
// RULE16 - Endpoint 1 not-empty source requests one byte while host buffer empty.
// RULE17 - IN source requests when host buffer full and FIFO within size; command ends it.
// RULE18 - Channel 0 wins; it preempts channel 1 bursts between byte pairs.
// RULE19 - CPU interrupt suspends transfer, sets suspend flag, resumes after service.
// RULE20 - Writing the enable bit during service resumes a suspended transfer.
// RULE21 - Software trigger self-clears when its request is accepted.
module dma_core #(
    parameter int AW = 16
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] irq_factors_0,
    input wire logic [7:0] irq_factors_1,
    input wire logic out_packet_ready,
    input wire logic ep1_fifo_not_empty,
    input wire logic [3:0] in_packet_ready,
    input wire logic in_fifo_within_size,
    input wire logic hb_out_empty,
    input wire logic hb_in_full,
    input wire logic hb_in_command,
    input wire logic cpu_irq_active,
    output dma_pkg::mem_req_t mem_req,
    input wire logic [7:0] mem_rdata,
    output logic dma_irq
);
    import dma_pkg::*;
    typedef enum logic [1:0] {IDLE, RD, WR} state_t;
    state_t st_r, st_nxt;
    chan_cfg_t cfg_r [2];
    logic [2:0] hwsel_r [2];
    logic [AW-1:0] src_r [2], dst_r [2], src_l_r [2], dst_l_r [2];
    logic [15:0] cnt_r [2], cnt_l_r [2];
    logic [1:0] pend_r, under_r, susp_r, soft_r, burst_r, resume_r;
    logic idx_r, reload_dis_r, irq_r, cur_r;
    logic [31:0] prdata_r;
    logic hw_req [2];
    wire access = psel && penable;
    wire wr_en = access && pwrite;
    wire rd_en = access && !pwrite;
    wire known = paddr <= `OFF_TRIGGER;
    wire idx = idx_r; // [RULE5]
    wire wr_is = wr_en && paddr == `OFF_INDEX_STATUS;
    wire wr_ml = wr_en && paddr == `OFF_MODE_LO;
    wire wr_mh = wr_en && paddr == `OFF_MODE_HI;
    wire wr_src = wr_en && paddr == `OFF_SRC;
    wire wr_dst = wr_en && paddr == `OFF_DST;
    wire wr_cnt = wr_en && paddr == `OFF_COUNT;
    wire wr_tr = wr_en && paddr == `OFF_TRIGGER;
    wire rd_is = rd_en && paddr == `OFF_INDEX_STATUS;
    wire busy = st_r != IDLE;
    // Channel 0 is picked first whenever a new pair can start. [RULE18]
    wire [1:0] ready_ch;
    wire [1:0] go_ch;
    wire pick = go_ch[0] ? 1'b0 : 1'b1;
    wire start = !busy && (go_ch != 2'b00); // [RULE19]
    wire done = st_r == WR;
    wire under = done && cnt_r[cur_r] == 16'h0000;
    assign pready = 1'b1;
    assign pslverr = access && !known;
    assign prdata = prdata_r;
    assign dma_irq = irq_r;

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_ch
            dma_request u_req (
                .hw_sel(hwsel_r[c]),
                .usb_en(cfg_r[c].usb_en),
                .mode_sel(cfg_r[c].mode_sel),
                .irq_factors(c == 0 ? irq_factors_0 : irq_factors_1),
                .out_packet_ready(out_packet_ready),
                .ep1_fifo_not_empty(ep1_fifo_not_empty),
                .in_packet_ready(in_packet_ready[hwsel_r[c][1:0]]),
                .in_fifo_within_size(in_fifo_within_size),
                .hb_out_empty(hb_out_empty),
                .hb_in_full(hb_in_full && !hb_in_command), // [RULE17]
                .hw_req(hw_req[c])
            );
            wire sel = idx == c;
            wire latch_only = cfg_r[c].latch_only;
            wire this_done = done && cur_r == c;
            wire this_under = under && cur_r == c;
            wire do_reload = wr_tr && sel && pwdata[`TR_RELOAD]; // [RULE13]
            wire trig = wr_tr && sel && pwdata[`TR_SOFT];
            wire en_wr = wr_ml && sel && pwdata[`ML_ENABLE];
            // A burst keeps its channel ready until the count runs out. [RULE4]
            assign ready_ch[c] = cfg_r[c].enable && (pend_r[c] || burst_r[c]);
            // An interrupt holds the channel back unless software resumed it. [RULE20]
            assign go_ch[c] = ready_ch[c] && (!cpu_irq_active || resume_r[c]); // [RULE19]
            always_ff @(posedge mclk) begin
                if (!reset_n) begin
                    cfg_r[c] <= '0;
                    hwsel_r[c] <= 3'h0;
                    src_r[c] <= '0;
                    dst_r[c] <= '0;
                    src_l_r[c] <= '0;
                    dst_l_r[c] <= '0;
                    cnt_r[c] <= `RESET_WORD;
                    cnt_l_r[c] <= `RESET_WORD;
                    pend_r[c] <= 1'b0;
                    soft_r[c] <= 1'b0;
                    burst_r[c] <= 1'b0;
                    under_r[c] <= 1'b0;
                    susp_r[c] <= 1'b0;
                    resume_r[c] <= 1'b0;
                end else begin
                    if (wr_ml && sel) begin
                        cfg_r[c].src_inc <= pwdata[`ML_SRC_INC];
                        cfg_r[c].src_dec <= pwdata[`ML_SRC_DEC];
                        cfg_r[c].dst_inc <= pwdata[`ML_DST_INC];
                        cfg_r[c].dst_dec <= pwdata[`ML_DST_DEC];
                        cfg_r[c].mode_sel <= pwdata[`ML_MODE_SEL];
                        cfg_r[c].latch_only <= pwdata[`ML_LATCH_ONLY];
                        cfg_r[c].dis_under <= pwdata[`ML_DIS_UNDER];
                        cfg_r[c].enable <= pwdata[`ML_ENABLE]; // [RULE20]
                    end else if (this_under && cfg_r[c].dis_under) begin
                        cfg_r[c].enable <= 1'b0; // [RULE12]
                    end
                    if (wr_mh && sel) begin
                        hwsel_r[c] <= pwdata[`MH_SRC_LSB+2:`MH_SRC_LSB];
                    end
                    if (wr_tr && sel) begin
                        cfg_r[c].usb_en <= pwdata[`TR_USB_EN];
                    end
                    // Latches take every write; working registers only without latch-only. [RULE6]
                    if (wr_src && sel) begin
                        src_l_r[c] <= pwdata[AW-1:0];
                    end
                    if (wr_dst && sel) begin
                        dst_l_r[c] <= pwdata[AW-1:0];
                    end
                    if (wr_cnt && sel) begin
                        cnt_l_r[c] <= pwdata[15:0];
                    end
                    if (do_reload || (this_under && !reload_dis_r)) begin
                        src_r[c] <= src_l_r[c]; // [RULE10]
                        dst_r[c] <= dst_l_r[c];
                    end else if (wr_src && sel && !latch_only) begin
                        src_r[c] <= pwdata[AW-1:0];
                    end else if (wr_dst && sel && !latch_only) begin
                        dst_r[c] <= pwdata[AW-1:0];
                    end else if (this_done) begin
                        // Pointer stepping after each byte pair. [RULE9]
                        if (cfg_r[c].src_inc) begin
                            src_r[c] <= src_r[c] + 1'b1;
                        end else if (cfg_r[c].src_dec) begin
                            src_r[c] <= src_r[c] - 1'b1;
                        end
                        if (cfg_r[c].dst_inc) begin
                            dst_r[c] <= dst_r[c] + 1'b1;
                        end else if (cfg_r[c].dst_dec) begin
                            dst_r[c] <= dst_r[c] - 1'b1;
                        end
                    end
                    if (do_reload || this_under) begin
                        cnt_r[c] <= cnt_l_r[c]; // [RULE10]
                    end else if (wr_cnt && sel && !latch_only) begin
                        cnt_r[c] <= pwdata[15:0];
                    end else if (this_done) begin
                        cnt_r[c] <= cnt_r[c] - 16'h0001;
                    end
                    // Software trigger sets a request and self-clears on acceptance. [RULE8]
                    soft_r[c] <= trig ? 1'b1 : (start && pick == c) ? 1'b0 : soft_r[c]; // [RULE21]
                    // One request is held per channel; a held hardware level re-arms it. [RULE3]
                    if (hw_req[c] || trig) begin
                        pend_r[c] <= 1'b1; // [RULE2]
                    end else if (start && pick == c) begin
                        pend_r[c] <= 1'b0;
                    end
                    if (start && pick == c && cfg_r[c].mode_sel) begin
                        burst_r[c] <= 1'b1;
                    end else if (this_under || !cfg_r[c].mode_sel) begin
                        burst_r[c] <= 1'b0;
                    end
                    // The set wins over a read clear of the underflow flag. [RULE11]
                    if (this_under) begin
                        under_r[c] <= 1'b1;
                    end else if (rd_is && sel) begin
                        under_r[c] <= 1'b0;
                    end
                    // Suspend flag follows a held interrupt on a live transfer. [RULE19]
                    resume_r[c] <= cpu_irq_active && (resume_r[c] || en_wr); // [RULE20]
                    susp_r[c] <= cpu_irq_active && ready_ch[c] && !resume_r[c] && !en_wr;
                end
            end
        end
    endgenerate

    // The channel in service stays fixed for a read and write pair; a burst of
    // channel 1 gives way to channel 0 only between pairs. [RULE18]
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            IDLE: if (start) st_nxt = RD;
            RD: st_nxt = WR;
            WR: st_nxt = IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_r <= IDLE;
            cur_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            if (start) begin
                cur_r <= pick;
            end
        end
    end

    // Memory port: read address in the read cycle, written byte in the write cycle. [RULE1]
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mem_req <= '0;
        end else begin
            mem_req.req <= st_nxt != IDLE;
            mem_req.wr <= st_nxt == WR;
            mem_req.addr <= (st_nxt == WR) ? dst_r[cur_r] : src_r[start ? pick : cur_r];
            mem_req.wdata <= mem_rdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            idx_r <= 1'b0;
            reload_dis_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            if (wr_is) begin
                idx_r <= pwdata[`IS_CHAN_INDEX];
                reload_dis_r <= pwdata[`IS_RELOAD_DIS];
            end
            // Interrupt request bit: set on underflow, write 1 clears, set wins. [RULE11]
            if (under) begin
                irq_r <= 1'b1;
            end else if (wr_is && pwdata[`IS_IRQ_REQ]) begin
                irq_r <= 1'b0;
            end
        end
    end

    wire [31:0] is_word = {24'h0, susp_r[1], susp_r[0], under_r[1], under_r[0],
                           1'b0, irq_r, reload_dis_r, idx_r};
    wire [31:0] ml_word = {24'h0, cfg_r[idx].enable, cfg_r[idx].dis_under,
                           cfg_r[idx].latch_only, cfg_r[idx].mode_sel, cfg_r[idx].dst_dec,
                           cfg_r[idx].dst_inc, cfg_r[idx].src_dec, cfg_r[idx].src_inc};
    wire [31:0] rd_word =
        (paddr == `OFF_INDEX_STATUS) ? is_word :
        (paddr == `OFF_MODE_LO) ? ml_word :
        (paddr == `OFF_MODE_HI) ? {29'h0, hwsel_r[idx]} :
        (paddr == `OFF_SRC) ? {{(32-AW){1'b0}}, src_r[idx]} :
        (paddr == `OFF_DST) ? {{(32-AW){1'b0}}, dst_r[idx]} :
        (paddr == `OFF_COUNT) ? {16'h0, cnt_r[idx]} :
        (paddr == `OFF_TRIGGER) ? {26'h0, cfg_r[idx].usb_en, 4'h0, soft_r[idx]} : 32'h0;

    // A whole word is read at once, so the byte order software keeps is harmless. [RULE7]
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            prdata_r <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= rd_word;
        end
    end
endmodule : dma_core

// ===== hw/dma_map.svh
// Register offsets, field positions and reset values of the two channel byte DMA.
`ifndef DMA_MAP_SVH
`define DMA_MAP_SVH
`define OFF_INDEX_STATUS 12'h000
`define OFF_MODE_LO 12'h004
`define OFF_MODE_HI 12'h008
`define OFF_SRC 12'h00c
`define OFF_DST 12'h010
`define OFF_COUNT 12'h014
`define OFF_TRIGGER 12'h018
`define OFF_CPU_IRQ 12'h01c
`define IS_CHAN_INDEX 0
`define IS_RELOAD_DIS 1
`define IS_IRQ_REQ 2
`define IS_UNDER0 4
`define IS_UNDER1 5
`define IS_SUSP0 6
`define IS_SUSP1 7
`define ML_SRC_INC 0
`define ML_SRC_DEC 1
`define ML_DST_INC 2
`define ML_DST_DEC 3
`define ML_MODE_SEL 4
`define ML_LATCH_ONLY 5
`define ML_DIS_UNDER 6
`define ML_ENABLE 7
`define MH_SRC_LSB 0
`define TR_SOFT 0
`define TR_RELOAD 1
`define TR_USB_EN 5
`define SRC_OUT_PKT 3'h1
`define SRC_EP1_NE 3'h2
`define SRC_IN_PKT 3'h3
`define RESET_WORD 16'h0000
`endif

// ===== hw/dma_pkg.sv
// Types shared by the byte DMA modules.
package dma_pkg;
    typedef struct packed {
        logic src_inc;
        logic src_dec;
        logic dst_inc;
        logic dst_dec;
        logic mode_sel;
        logic latch_only;
        logic dis_under;
        logic enable;
        logic usb_en;
        logic [2:0] hw_sel;
    } chan_cfg_t;
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic [7:0] wdata;
        logic req;
    } mem_req_t;
endpackage : dma_pkg

// ===== hw/dma_request.sv
// Request source selection for one channel.
`timescale 1ns/10ps
`include "dma_map.svh"
module dma_request (
    input wire logic [2:0] hw_sel,
    input wire logic usb_en,
    input wire logic mode_sel,
    input wire logic [7:0] irq_factors,
    input wire logic out_packet_ready,
    input wire logic ep1_fifo_not_empty,
    input wire logic in_packet_ready,
    input wire logic in_fifo_within_size,
    input wire logic hb_out_empty,
    input wire logic hb_in_full,
    output logic hw_req
);
    wire usb_src = (hw_sel == `SRC_OUT_PKT) || (hw_sel == `SRC_EP1_NE) || (hw_sel == `SRC_IN_PKT);
    wire usb_path = usb_en && usb_src && !mode_sel; // [RULE14]
    wire out_req = out_packet_ready && hb_out_empty; // [RULE15]
    wire ne_req = ep1_fifo_not_empty && hb_out_empty; // [RULE16]
    wire in_req = !in_packet_ready && hb_in_full && in_fifo_within_size; // [RULE17]
    wire usb_req = (hw_sel == `SRC_OUT_PKT) ? out_req : (hw_sel == `SRC_EP1_NE) ? ne_req : in_req;
    assign hw_req = usb_path ? usb_req : irq_factors[hw_sel]; // [RULE2]
endmodule : dma_request

// ===== tb/dma_mem_model.sv
// Byte memory partner that answers the core's read cycles.
`timescale 1ns/10ps
module dma_mem_model (
    input wire logic mclk,
    input wire dma_pkg::mem_req_t mem_req,
    output logic [7:0] mem_rdata
);
    import dma_pkg::*;
    logic [7:0] last_r = 8'h00;
    // A read is answered in its own cycle; outside reads the bus shows a changing pattern.
    assign mem_rdata = (mem_req.req && !mem_req.wr) ?
        (mem_req.addr[7:0] ^ mem_req.addr[15:8] ^ 8'h3c) : ~last_r;
    always_ff @(posedge mclk) begin
        last_r <= mem_rdata;
    end
endmodule : dma_mem_model

// ===== tb/dma_checker.sv
// Concurrent checks on the byte DMA core's ports.
`timescale 1ns/10ps
module dma_checker (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cpu_irq_active,
    input wire dma_pkg::mem_req_t mem_req,
    input wire logic [7:0] mem_rdata,
    input wire logic dma_irq
);
    import dma_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic resume_seen;
    // An enable write during an interrupt lets the held transfer go on.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            resume_seen <= 1'b0;
        end else begin
            resume_seen <= cpu_irq_active && (resume_seen ||
                (psel && penable && pwrite && paddr == 12'h004 && pwdata[7]));
        end
    end
    sequence rd_s;
        mem_req.req && !mem_req.wr;
    endsequence
    sequence wr_s;
        mem_req.req && mem_req.wr;
    endsequence
    ready_high_a: assert property (pready) else $error("pready low");
    decode_error_a: assert property (pslverr == (psel && penable && paddr > 12'h018))
        else $error("pslverr wrong");
    read_then_write_a: assert property (rd_s |=> wr_s ##0 mem_req.wdata == $past(mem_rdata))
        else $error("write does not follow read");
    pair_gap_a: assert property (wr_s |=> !mem_req.req) else $error("no idle after write");
    write_cause_a: assert property (wr_s |-> $past(mem_req.req && !mem_req.wr))
        else $error("write without read");
    suspend_hold_a: assert property (cpu_irq_active [*3] ##0 !resume_seen |->
        !(mem_req.req && !mem_req.wr)) else $error("read while suspended");
    irq_source_a: assert property ($rose(dma_irq) |-> $past(mem_req.req) || $past(mem_req.req, 2))
        else $error("irq without transfer");
    irq_clear_a: assert property ($fell(dma_irq) |-> $past(psel && penable && pwrite))
        else $error("irq cleared without write");
    reset_quiet_a: assert property (disable iff (1'b0) !reset_n |=> !mem_req.req && !dma_irq)
        else $error("activity in reset");
endmodule : dma_checker
bind dma_core dma_checker u_dma_checker (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .pwdata(pwdata), .cpu_irq_active(cpu_irq_active), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .dma_irq(dma_irq));

// ===== tb/tb_top.sv
// Self-checking bench for the two channel byte DMA core.
`timescale 1ns/10ps
`include "dma_map.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
    import dma_pkg::*;
    logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, err, dma_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] irq_factors_0, irq_factors_1, hw_pulse, mem_rdata;
    logic [3:0] in_packet_ready;
    logic out_packet_ready, ep1_fifo_not_empty, in_fifo_within_size, hb_out_empty;
    logic hb_in_full, hb_in_command, cpu_irq_active;
    mem_req_t mem_req;
    logic [23:0] wq[$];
    logic [15:0] s, d, s2, c;
    int n_fail, n_checks, seed = 77;
    dma_core u_dma_core (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_factors_0(irq_factors_0), .irq_factors_1(irq_factors_1),
        .out_packet_ready(out_packet_ready), .ep1_fifo_not_empty(ep1_fifo_not_empty),
        .in_packet_ready(in_packet_ready), .in_fifo_within_size(in_fifo_within_size),
        .hb_out_empty(hb_out_empty), .hb_in_full(hb_in_full), .hb_in_command(hb_in_command),
        .cpu_irq_active(cpu_irq_active), .mem_req(mem_req), .mem_rdata(mem_rdata),
        .dma_irq(dma_irq));
    dma_mem_model u_dma_mem_model (.mclk(mclk), .mem_req(mem_req), .mem_rdata(mem_rdata));
    function automatic logic [7:0] fb(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction : fb
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic setup(input logic ch, input logic [7:0] m, input logic [15:0] cnt);
        apb(1'b1, `OFF_INDEX_STATUS, {31'h0, ch});
        apb(1'b1, `OFF_MODE_LO, {24'h0, m});
        apb(1'b1, `OFF_SRC, {16'h0, s});
        apb(1'b1, `OFF_DST, {16'h0, d});
        apb(1'b1, `OFF_COUNT, {16'h0, cnt});
    endtask : setup
    task automatic exp_wr(input logic [15:0] sa, input logic [15:0] da);
        logic [23:0] w;
        for (int i = 0; i < 200 && wq.size() == 0; i++) @(posedge mclk);
        w = (wq.size() > 0) ? wq.pop_front() : 24'hxxxxxx;
        `CHK(w, {da, fb(sa)})
    endtask : exp_wr
    task automatic quiet;
        repeat (20) @(posedge mclk);
        `CHK(32'(wq.size()), 32'h0)
    endtask : quiet
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Side inputs toggle at random; bits 0 and 4 of the factors stay quiet for directed use.
    always @(posedge mclk) begin
        irq_factors_0 <= ($random(seed) & 8'hee) | hw_pulse;
        irq_factors_1 <= $random(seed) & 8'hee;
        {out_packet_ready, ep1_fifo_not_empty, in_packet_ready} <= $random(seed);
        {in_fifo_within_size, hb_out_empty, hb_in_full, hb_in_command} <= $random(seed);
        if (reset_n && mem_req.req && mem_req.wr) wq.push_back({mem_req.addr, mem_req.wdata});
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        results();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, cpu_irq_active, hw_pulse} = '0;
        {irq_factors_0, irq_factors_1, in_packet_ready, out_packet_ready} = '0;
        {ep1_fifo_not_empty, in_fifo_within_size, hb_out_empty, hb_in_full, hb_in_command} = '0;
        reset_n = 1'b0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        for (int a = 0; a <= 'h18; a += 4) begin
            apb(1'b0, 12'(a), 32'h0);
            `CHK(rd, 32'h0)
        end
        apb(1'b0, 12'h020, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        $display("reset and decode done");
        s = $random(seed);
        d = $random(seed);
        setup(1'b0, 8'h85, 16'h0001);
        apb(1'b1, `OFF_TRIGGER, 32'h1);
        exp_wr(s, d);
        apb(1'b0, `OFF_TRIGGER, 32'h0);
        `CHK(rd[0], 1'b0)
        quiet();
        apb(1'b1, `OFF_TRIGGER, 32'h1);
        exp_wr(s + 16'h1, d + 16'h1);
        apb(1'b0, `OFF_INDEX_STATUS, 32'h0);
        `CHK({dma_irq, rd[4]}, 2'b11)
        apb(1'b1, `OFF_TRIGGER, 32'h1);
        exp_wr(s, d);
        apb(1'b1, `OFF_INDEX_STATUS, 32'h4);
        @(posedge mclk);
        `CHK(dma_irq, 1'b0)
        $display("cycle steal done");
        c = 16'($random(seed) & 3) + 16'h1;
        setup(1'b1, 8'hda, c);
        apb(1'b1, `OFF_TRIGGER, 32'h1);
        for (int i = 0; i <= c; i++) exp_wr(s - 16'(i), d - 16'(i));
        apb(1'b0, `OFF_MODE_LO, 32'h0);
        `CHK(rd[7], 1'b0)
        apb(1'b1, `OFF_INDEX_STATUS, 32'h6);
        apb(1'b0, `OFF_MODE_LO, 32'h0);
        `CHK(rd[7:0], 8'h85)
        $display("burst done");
        s2 = $random(seed);
        apb(1'b1, `OFF_MODE_LO, 32'ha5);
        apb(1'b1, `OFF_SRC, {16'h0, s2});
        apb(1'b1, `OFF_TRIGGER, 32'h1);
        exp_wr(s + 16'h1, d + 16'h1);
        apb(1'b1, `OFF_TRIGGER, 32'h2);
        apb(1'b1, `OFF_MODE_LO, 32'h85);
        cpu_irq_active <= 1'b1;
        apb(1'b1, `OFF_TRIGGER, 32'h1);
        quiet();
        apb(1'b0, `OFF_INDEX_STATUS, 32'h0);
        `CHK(rd[6], 1'b1)
        cpu_irq_active <= 1'b0;
        exp_wr(s2, d);
        apb(1'b1, `OFF_MODE_HI, 32'h4);
        hw_pulse <= 8'h10;
        @(posedge mclk);
        hw_pulse <= 8'h00;
        exp_wr(s2 + 16'h1, d + 16'h1);
        cpu_irq_active <= 1'b1;
        apb(1'b1, `OFF_TRIGGER, 32'h1);
        apb(1'b1, `OFF_MODE_LO, 32'h85);
        exp_wr(s2 + 16'h2, d + 16'h2);
        cpu_irq_active <= 1'b0;
        $display("latch, suspend and hardware request done");
        results();
    end
endmodule : tb_top
